// ===== rtl/pfs_dead_time.sv
// Gate driver sequencer with built-in or programmable dead time
module pfs_dead_time
   import pfs_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                clk_en,
   input  wire logic                chan_enable,
   input  wire logic                pwm_demand,
   input  wire logic                prog_sel,
   input  wire logic [DT_W-1:0]     rise_count,
   input  wire logic [DT_W-1:0]     fall_count,
   input  wire logic [PERIOD_W-1:0] step_cycles,
   output logic                     high_side_on,
   output logic                     low_side_on
);
   pfs_dt_state_t         state_reg, state_next;
   logic                  target_reg, target_next;
   logic [DT_CNT_W-1:0]   cnt_reg, cnt_next;
   logic [DT_CNT_W-1:0]   gap_rise, gap_fall;
   logic                  hs_next, ls_next;

   // Both switches are off through every gap, so they never conduct together
   always_comb begin
      gap_rise = prog_sel ? DT_CNT_W'(rise_count) * DT_CNT_W'(step_cycles)
                          : DT_BUILTIN_GAP;
      gap_fall = prog_sel ? DT_CNT_W'(fall_count) * DT_CNT_W'(step_cycles)
                          : DT_BUILTIN_GAP;
      state_next  = state_reg;
      target_next = target_reg;
      cnt_next    = cnt_reg;
      unique case (state_reg)
         DT_OFF: begin
            if (chan_enable) begin
               state_next  = DT_GAP;
               target_next = pwm_demand;
               cnt_next    = pwm_demand ? gap_rise : gap_fall;
            end
         end
         DT_LOW: begin
            if (!chan_enable) begin
               state_next = DT_OFF;
            end else if (pwm_demand) begin
               state_next  = DT_GAP;
               target_next = 1'b1;
               cnt_next    = gap_rise;
            end
         end
         DT_HIGH: begin
            if (!chan_enable) begin
               state_next = DT_OFF;
            end else if (!pwm_demand) begin
               state_next  = DT_GAP;
               target_next = 1'b0;
               cnt_next    = gap_fall;
            end
         end
         DT_GAP: begin
            if (!chan_enable) begin
               state_next = DT_OFF;
            end else if (cnt_reg == '0) begin
               state_next = target_reg ? DT_HIGH : DT_LOW;
            end else begin
               cnt_next = cnt_reg - DT_CNT_ONE;
            end
         end
      endcase
      hs_next = (state_next == DT_HIGH);
      ls_next = (state_next == DT_LOW);
   end

   // Gate levels come straight from flops to avoid glitches
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg    <= DT_OFF;
         target_reg   <= 1'b0;
         cnt_reg      <= '0;
         high_side_on <= 1'b0;
         low_side_on  <= 1'b0;
      end else if (clk_en) begin
         state_reg    <= state_next;
         target_reg   <= target_next;
         cnt_reg      <= cnt_next;
         high_side_on <= hs_next;
         low_side_on  <= ls_next;
      end
   end

   a_no_overlap: assert property (@(posedge clk) disable iff (reset)
      !(high_side_on && low_side_on)) else $error("both gates on");
endmodule

// ===== rtl/pfs_pkg.sv
// Shared constants and types for the power enable and fault supervisor
package pfs_pkg;
   localparam int unsigned NUM_CH   = 4;
   localparam int unsigned NUM_VIN  = 2;
   localparam int unsigned VOLT_W   = 8;
   localparam int unsigned TEMP_W   = 7;
   localparam int unsigned PERIOD_W = 16;
   localparam int unsigned DT_W     = 8;
   localparam int unsigned DT_CNT_W = PERIOD_W + DT_W;

   // Clock rate and the overcurrent restart delay
   localparam int unsigned CLK_MHZ            = 200;
   localparam int unsigned OCP_RESTART_MS     = 200;
   localparam int unsigned OCP_RESTART_CYCLES = OCP_RESTART_MS * 1000 * CLK_MHZ;
   localparam int unsigned OCP_CNT_W          = 26;

   // Temperature codes are kelvin divided by five
   localparam logic [TEMP_W-1:0] TEMP_MIN_CODE    = 7'h28;
   localparam logic [TEMP_W-1:0] TEMP_MAX_CODE    = 7'h68;
   localparam logic [TEMP_W:0]   OT_MARGIN_SMALL  = 8'h01;
   localparam logic [TEMP_W:0]   OT_MARGIN_LARGE  = 8'h02;

   // One dead-time count is the switching period over 256
   localparam int unsigned        DT_STEP_SHIFT  = 8;
   localparam logic [PERIOD_W-1:0] DT_STEP_MIN   = 16'h0001;
   localparam logic [DT_CNT_W-1:0] DT_BUILTIN_GAP = 24'h000002;
   localparam logic [DT_CNT_W-1:0] DT_CNT_ONE     = 24'h000001;

   typedef enum logic [1:0] {
      SRC_OFF    = 2'b00,
      SRC_ALWAYS = 2'b01,
      SRC_GPIO   = 2'b10,
      SRC_SERIAL = 2'b11
   } pfs_src_t;

   typedef enum logic [1:0] {
      CHIP_DISABLED   = 2'b00,
      CHIP_STARTUP    = 2'b01,
      CHIP_RUN        = 2'b10,
      CHIP_SOFT_RESET = 2'b11
   } pfs_chip_state_t;

   typedef enum logic [1:0] {
      DT_OFF  = 2'b00,
      DT_LOW  = 2'b01,
      DT_HIGH = 2'b10,
      DT_GAP  = 2'b11
   } pfs_dt_state_t;

   typedef struct packed {
      logic [VOLT_W-1:0] warn;
      logic [VOLT_W-1:0] fault;
   } pfs_uv_cfg_t;

   typedef struct packed {
      logic [NUM_VIN-1:0] uv_warn;
      logic [NUM_VIN-1:0] uv_fault;
      logic               ot_warn;
      logic               ot_fault;
      logic [NUM_CH-1:0]  output_overvoltage_protection;
      logic [NUM_CH-1:0]  overcurrent_protection;
   } pfs_flags_t;
endpackage

// ===== rtl/pfs_supervisor.sv
// Chip enable, channel enable and fault supervisor for four buck channels
// Operation
// - Enable raises ready; serial acks only after ready
// - Ready enables always-on and asserted GPIO channels
// - Enable low disables device; high re-enables it
// - Serial software reset command resets the chip
// - Channels enable from default, GPIO or serial
// - Built-in non-overlap, bypassed under programmable dead time
// - Control bit selects programmable or built-in dead time
// - Rise and fall registers set each gap
// - Dead-time count is switching period over 256
// - Input below warning threshold sets warning flag
// - Input below fault threshold sets fault flag
// - Undervoltage fault shuts down all channels
// - Input voltages readable at 100mV per count
// - Clears above warning; optional automatic restart
// - Output overvoltage shuts down that channel
// - Overcurrent shuts channel, restarts after 200ms
// - Junction temperature reads 200K to 520K, 5K steps
// - Temperature warning at 5 or 10 below threshold
// - Over-temperature fault sets both flags, shuts all
// - Seven-bit thermal fault threshold, 5K per count
// - Optional restart below separate restart threshold
// - Overvoltage channel and followers wait for host
module pfs_supervisor
   import pfs_pkg::*;
#(
   parameter int unsigned OCP_RESTART = OCP_RESTART_CYCLES
)
(
   input  wire logic                            clk,
   input  wire logic                            reset,
   input  wire logic                            clk_en,
   input  wire logic                            enable_in,
   input  wire logic [NUM_CH-1:0]               gpio_enable_in,
   input  wire logic                            software_reset_command,
   input  wire pfs_src_t [NUM_CH-1:0]           enable_source,
   input  wire logic [NUM_CH-1:0]               serial_channel_enable,
   input  wire logic [NUM_CH-1:0]               channel_reenable,
   input  wire logic [NUM_CH-1:0][NUM_CH-1:0]   ovp_follow,
   input  wire logic [NUM_CH-1:0][NUM_CH-1:0]   ocp_follow,
   input  wire logic [NUM_CH-1:0]               ovp_trip,
   input  wire logic [NUM_CH-1:0]               ocp_trip,
   input  wire logic [NUM_VIN-1:0][VOLT_W-1:0]  input_sense,
   input  wire pfs_uv_cfg_t [NUM_VIN-1:0]       uv_cfg,
   input  wire logic                            uv_auto_restart,
   input  wire logic [TEMP_W-1:0]               temp_sense,
   input  wire logic [TEMP_W-1:0]               thermal_fault_threshold,
   input  wire logic [TEMP_W-1:0]               thermal_restart_threshold,
   input  wire logic                            ot_margin_large,
   input  wire logic                            ot_auto_restart,
   input  wire logic                            programmable_dead_time,
   input  wire logic [NUM_CH-1:0][DT_W-1:0]     rise_dead_time,
   input  wire logic [NUM_CH-1:0][DT_W-1:0]     fall_dead_time,
   input  wire logic [PERIOD_W-1:0]             pwm_period_cycles,
   input  wire logic [NUM_CH-1:0]               pwm_demand,
   output logic                                 device_ready,
   output logic                                 serial_ack_allowed,
   output logic [NUM_CH-1:0]                    channel_active,
   output logic [VOLT_W-1:0]                    input_one_voltage,
   output logic [VOLT_W-1:0]                    input_two_voltage,
   output logic [TEMP_W-1:0]                    junction_temperature,
   output pfs_flags_t                           protection_flag_status,
   output logic                                 uv_warning_gpio,
   output logic [NUM_CH-1:0]                    high_side_gate,
   output logic [NUM_CH-1:0]                    low_side_gate
);
   // Two-flop synchronisers; first stage feeds only the second
   logic                  en_meta_reg, en_sync_reg;
   logic [NUM_CH-1:0]     gpio_meta_reg, gpio_sync_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         en_meta_reg   <= 1'b0;
         en_sync_reg   <= 1'b0;
         gpio_meta_reg <= '0;
         gpio_sync_reg <= '0;
      end else if (clk_en) begin
         en_meta_reg   <= enable_in;
         en_sync_reg   <= en_meta_reg;
         gpio_meta_reg <= gpio_enable_in;
         gpio_sync_reg <= gpio_meta_reg;
      end
   end

   // Chip state: enable pin acts as the chip-level reset
   pfs_chip_state_t state_reg, state_next;
   logic            ready_next;
   logic            clear_all;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         CHIP_DISABLED: begin
            if (en_sync_reg) begin
               state_next = CHIP_STARTUP;
            end
         end
         CHIP_STARTUP: begin
            state_next = en_sync_reg ? CHIP_RUN : CHIP_DISABLED;
         end
         CHIP_RUN: begin
            if (!en_sync_reg) begin
               state_next = CHIP_DISABLED;
            end else if (software_reset_command) begin
               state_next = CHIP_SOFT_RESET;
            end
         end
         CHIP_SOFT_RESET: begin
            state_next = CHIP_DISABLED;
         end
      endcase
      ready_next = (state_next == CHIP_STARTUP) || (state_next == CHIP_RUN);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg    <= CHIP_DISABLED;
         device_ready <= 1'b0;
      end else if (clk_en) begin
         state_reg    <= state_next;
         device_ready <= ready_next;
      end
   end

   // Commands are only acknowledged once the chip is ready
   assign serial_ack_allowed = device_ready;
   // Disabled and soft-reset states wipe every latch, like a power cycle
   assign clear_all = (state_reg == CHIP_DISABLED) || (state_reg == CHIP_SOFT_RESET);

   // Input undervoltage: warning, fault and shared shutdown
   logic [NUM_VIN-1:0] uv_warn_reg, uv_warn_next;
   logic [NUM_VIN-1:0] uv_fault_reg, uv_fault_next;
   logic               uv_shut_reg, uv_shut_next;

   always_comb begin
      uv_shut_next = uv_shut_reg;
      for (int k = 0; k < NUM_VIN; k++) begin
         uv_warn_next[k]  = input_sense[k] <= uv_cfg[k].warn;
         uv_fault_next[k] = uv_fault_reg[k];
         if (input_sense[k] > uv_cfg[k].warn) begin
            uv_fault_next[k] = 1'b0;
         end
         if (input_sense[k] <= uv_cfg[k].fault) begin
            uv_fault_next[k] = 1'b1;
         end
      end
      // Without auto restart only an enable cycle or soft reset recovers
      if (uv_auto_restart && !(|uv_fault_next)) begin
         uv_shut_next = 1'b0;
      end
      if (|uv_fault_next) begin
         uv_shut_next = 1'b1;
      end
      if (clear_all) begin
         uv_fault_next = '0;
         uv_shut_next  = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         uv_warn_reg  <= '0;
         uv_fault_reg <= '0;
         uv_shut_reg  <= 1'b0;
      end else if (clk_en) begin
         uv_warn_reg  <= uv_warn_next;
         uv_fault_reg <= uv_fault_next;
         uv_shut_reg  <= uv_shut_next;
      end
   end

   // Over-temperature: warning margin, latched fault, restart point
   logic [TEMP_W:0]   ot_margin;
   logic              ot_warn_reg, ot_warn_next;
   logic              ot_fault_reg, ot_fault_next;
   logic              ot_shut_reg, ot_shut_next;
   logic [TEMP_W-1:0] temp_next;

   always_comb begin
      ot_margin     = ot_margin_large ? OT_MARGIN_LARGE : OT_MARGIN_SMALL;
      ot_fault_next = ot_fault_reg;
      ot_shut_next  = ot_shut_reg;
      if (temp_sense <= thermal_restart_threshold) begin
         ot_fault_next = 1'b0;
      end
      if (temp_sense >= thermal_fault_threshold) begin
         ot_fault_next = 1'b1;
      end
      // Widened sum so a high reading cannot wrap below threshold
      ot_warn_next = ({1'b0, temp_sense} + ot_margin >= {1'b0, thermal_fault_threshold})
                     || ot_fault_next;
      if (ot_auto_restart && !ot_fault_next) begin
         ot_shut_next = 1'b0;
      end
      if (ot_fault_next) begin
         ot_shut_next = 1'b1;
      end
      if (clear_all) begin
         ot_fault_next = 1'b0;
         ot_shut_next  = 1'b0;
      end
      // Clamp the readback to the measurable range
      temp_next = temp_sense;
      if (temp_sense < TEMP_MIN_CODE) begin
         temp_next = TEMP_MIN_CODE;
      end else if (temp_sense > TEMP_MAX_CODE) begin
         temp_next = TEMP_MAX_CODE;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ot_warn_reg          <= 1'b0;
         ot_fault_reg         <= 1'b0;
         ot_shut_reg          <= 1'b0;
         junction_temperature <= TEMP_MIN_CODE;
         input_one_voltage    <= '0;
         input_two_voltage    <= '0;
      end else if (clk_en) begin
         ot_warn_reg          <= ot_warn_next;
         ot_fault_reg         <= ot_fault_next;
         ot_shut_reg          <= ot_shut_next;
         junction_temperature <= temp_next;
         input_one_voltage    <= input_sense[0];
         input_two_voltage    <= input_sense[1];
      end
   end

   // Dead-time step shared by all channels, never below one cycle
   logic [PERIOD_W-1:0] dt_step;

   always_comb begin
      dt_step = pwm_period_cycles >> DT_STEP_SHIFT;
      if (dt_step == '0) begin
         dt_step = DT_STEP_MIN;
      end
   end

   // Per-channel enable, overvoltage latch and overcurrent restart timer
   logic [NUM_CH-1:0] chan_en_reg, chan_en_next;
   logic [NUM_CH-1:0] ovp_lat_reg, ovp_lat_next;
   logic [NUM_CH-1:0] ocp_hold;
   logic [NUM_CH-1:0] active_next;
   logic [OCP_CNT_W-1:0] ocp_cnt_reg [NUM_CH];
   logic [OCP_CNT_W-1:0] ocp_cnt_next [NUM_CH];

   for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
      logic ovp_hit, ocp_hit;

      always_comb begin
         ovp_hit = ovp_trip[i];
         ocp_hit = ocp_trip[i];
         for (int j = 0; j < NUM_CH; j++) begin
            ovp_hit = ovp_hit || (ovp_trip[j] && ovp_follow[j][i]);
            ocp_hit = ocp_hit || (ocp_trip[j] && ocp_follow[j][i]);
         end
         // Source select; serial control only once the chip runs
         unique case (enable_source[i])
            SRC_OFF:    chan_en_next[i] = 1'b0;
            SRC_ALWAYS: chan_en_next[i] = ready_next;
            SRC_GPIO:   chan_en_next[i] = ready_next && gpio_sync_reg[i];
            SRC_SERIAL: chan_en_next[i] = (state_reg == CHIP_RUN) && (state_next == CHIP_RUN)
                                          && serial_channel_enable[i];
         endcase
         // Set wins over the host re-enable in the same cycle
         ovp_lat_next[i] = ovp_lat_reg[i];
         if (channel_reenable[i]) begin
            ovp_lat_next[i] = 1'b0;
         end
         if (ovp_hit) begin
            ovp_lat_next[i] = 1'b1;
         end
         ocp_cnt_next[i] = ocp_cnt_reg[i];
         if (ocp_hit) begin
            ocp_cnt_next[i] = OCP_CNT_W'(OCP_RESTART);
         end else if (ocp_cnt_reg[i] != '0) begin
            ocp_cnt_next[i] = ocp_cnt_reg[i] - OCP_CNT_W'(1);
         end
         if (clear_all) begin
            ovp_lat_next[i] = 1'b0;
            ocp_cnt_next[i] = '0;
         end
         active_next[i] = chan_en_next[i] && !uv_shut_next && !ot_shut_next
                          && !ovp_lat_next[i] && (ocp_cnt_next[i] == '0);
      end

      always_ff @(posedge clk) begin
         if (reset) begin
            chan_en_reg[i]    <= 1'b0;
            ovp_lat_reg[i]    <= 1'b0;
            ocp_cnt_reg[i]    <= '0;
            channel_active[i] <= 1'b0;
         end else if (clk_en) begin
            chan_en_reg[i]    <= chan_en_next[i];
            ovp_lat_reg[i]    <= ovp_lat_next[i];
            ocp_cnt_reg[i]    <= ocp_cnt_next[i];
            channel_active[i] <= active_next[i];
         end
      end

      assign ocp_hold[i] = (ocp_cnt_reg[i] != '0);

      pfs_dead_time u_dead_time (
         .clk          (clk),
         .reset        (reset),
         .clk_en       (clk_en),
         .chan_enable  (channel_active[i]),
         .pwm_demand   (pwm_demand[i]),
         .prog_sel     (programmable_dead_time),
         .rise_count   (rise_dead_time[i]),
         .fall_count   (fall_dead_time[i]),
         .step_cycles  (dt_step),
         .high_side_on (high_side_gate[i]),
         .low_side_on  (low_side_gate[i])
      );

      a_ovp_stays_off: assert property (@(posedge clk) disable iff (reset)
         ovp_lat_reg[i] && !channel_reenable[i] && !clear_all && clk_en
         |=> ovp_lat_reg[i] && !channel_active[i]) else $error("ovp released");
      a_ocp_timer_load: assert property (@(posedge clk) disable iff (reset)
         ocp_trip[i] && !clear_all && clk_en
         |=> ocp_cnt_reg[i] == OCP_CNT_W'(OCP_RESTART) && !channel_active[i])
         else $error("ocp delay not loaded");
      a_always_on_start: assert property (@(posedge clk) disable iff (reset)
         state_reg == CHIP_DISABLED && en_sync_reg && clk_en
         && enable_source[i] == SRC_ALWAYS |=> chan_en_reg[i])
         else $error("always-on channel not enabled");
   end

   // Status flags come from flops
   always_comb begin
      uv_warning_gpio = uv_warn_reg != '0;
      protection_flag_status.uv_warn  = uv_warn_reg;
      protection_flag_status.uv_fault = uv_fault_reg;
      protection_flag_status.ot_warn  = ot_warn_reg;
      protection_flag_status.ot_fault = ot_fault_reg;
      protection_flag_status.output_overvoltage_protection      = ovp_lat_reg;
      protection_flag_status.overcurrent_protection      = ocp_hold;
   end

   a_ready_on_enable: assert property (@(posedge clk) disable iff (reset)
      state_reg == CHIP_DISABLED && en_sync_reg && clk_en
      |=> device_ready && serial_ack_allowed) else $error("ready not raised");
   a_enable_drop_off: assert property (@(posedge clk) disable iff (reset)
      state_reg == CHIP_RUN && !en_sync_reg && clk_en
      |=> !device_ready && state_reg == CHIP_DISABLED) else $error("not disabled");
   a_soft_reset_seq: assert property (@(posedge clk) disable iff (reset)
      state_reg == CHIP_RUN && en_sync_reg && software_reset_command && clk_en
      |=> state_reg == CHIP_SOFT_RESET && !device_ready) else $error("no reset");
   a_uv_shuts_all: assert property (@(posedge clk) disable iff (reset)
      (|uv_fault_reg) |-> channel_active == '0) else $error("uv left on");
   a_ot_shuts_all: assert property (@(posedge clk) disable iff (reset)
      ot_fault_reg |-> ot_warn_reg && channel_active == '0)
      else $error("ot left on");
endmodule

// ===== test/pfs_host_model.sv
// Host model that drives the chip enable pin
module pfs_host_model (
   input  wire logic supply_good,
   input  wire logic want_enable,
   output logic      enable_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Enable stays low until the core supply regulates
   assign enable_in = want_enable & supply_good;
endmodule

// ===== test/tb_top.sv
// Self-checking testbench for the power enable and fault supervisor
module tb_top
   import pfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RST = 20;
   logic clk = 0, reset = 1, want_en = 0, supply_good = 0, enable_in, clk_en;
   logic software_reset_command, uv_auto_restart, ot_margin_large, ot_auto_restart;
   logic programmable_dead_time, device_ready, serial_ack_allowed, uv_warning_gpio;
   logic [NUM_CH-1:0] gpio_enable_in, serial_channel_enable, channel_reenable, ovp_trip;
   logic [NUM_CH-1:0] ocp_trip, pwm_demand, channel_active, high_side_gate, low_side_gate;
   pfs_src_t [NUM_CH-1:0] enable_source;
   logic [NUM_CH-1:0][NUM_CH-1:0] ovp_follow, ocp_follow;
   logic [NUM_VIN-1:0][VOLT_W-1:0] input_sense;
   pfs_uv_cfg_t [NUM_VIN-1:0] uv_cfg;
   logic [TEMP_W-1:0] temp_sense, thermal_fault_threshold, thermal_restart_threshold;
   logic [TEMP_W-1:0] junction_temperature;
   logic [NUM_CH-1:0][DT_W-1:0] rise_dead_time, fall_dead_time;
   logic [PERIOD_W-1:0] pwm_period_cycles;
   logic [VOLT_W-1:0] input_one_voltage, input_two_voltage;
   pfs_flags_t protection_flag_status;
   int n_fail = 0, n_checks = 0;
   logic rnd = 1;
   pfs_host_model pfs_host_model_i (.supply_good, .want_enable(want_en), .enable_in);
   pfs_supervisor #(.OCP_RESTART(RST)) pfs_supervisor_i (.clk, .reset, .clk_en, .enable_in,
      .gpio_enable_in, .software_reset_command, .enable_source, .serial_channel_enable,
      .channel_reenable, .ovp_follow, .ocp_follow, .ovp_trip, .ocp_trip, .input_sense, .uv_cfg,
      .uv_auto_restart, .temp_sense, .thermal_fault_threshold, .thermal_restart_threshold,
      .ot_margin_large, .ot_auto_restart, .programmable_dead_time, .rise_dead_time,
      .fall_dead_time, .pwm_period_cycles, .pwm_demand, .device_ready, .serial_ack_allowed,
      .channel_active, .input_one_voltage, .input_two_voltage, .junction_temperature,
      .protection_flag_status, .uv_warning_gpio, .high_side_gate, .low_side_gate);
   always #2.5 clk = ~clk;
   task automatic summarize;
      if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // Inputs move 1 ns after the edge; modulator demand and mode churn at random
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         if (rnd) begin
            pwm_demand = 4'($urandom);
            programmable_dead_time = 1'($urandom);
         end
      end
   endtask
   // Edges from demand rise to channel 0 high side on; a run-out ends the run
   task automatic gap_edges(output int n);
      pwm_demand = '0;
      step(1);
      for (n = 0; n < 2000 && !low_side_gate[0]; n++) step(1);
      if (n < 2000) begin
         pwm_demand = '1;
         for (n = 0; n < 2000 && !high_side_gate[0]; n++) step(1);
      end
      if (n == 2000) begin
         n_fail++;
         summarize();
      end
   endtask
   // Rise gap plus entry and exit edges; one count is the period over 256
   function automatic int exp_gap(input logic p, input int cnt, input int per);
      int st;
      st = (per / 256 == 0) ? 1 : per / 256;
      return p ? cnt * st + 2 : int'(DT_BUILTIN_GAP) + 2;
   endfunction
   // Bounded wait for a channel pattern; running out ends the run
   task automatic wait_act(input logic [3:0] exp);
      int k;
      for (k = 0; k < 400 && channel_active !== exp; k++) step(1);
      chk("channel_active", channel_active, exp);
      if (k == 400) summarize();
   endtask
   // Ch0 always-on, ch1..2 from GPIO, ch3 serial
   function automatic logic [3:0] exp_on(input logic [3:0] g, input logic ser);
      return {ser, g[2:1], 1'b1};
   endfunction
   // Both switches of a channel never conduct together
   always @(negedge clk) if (!reset) chk("gate overlap", high_side_gate & low_side_gate, 0);
   initial begin
      logic [3:0] g;
      logic [7:0] v;
      int n;
      void'($urandom(68));
      g = 4'($urandom);
      v = 8'h41 + $urandom_range(0, 8'hBE);
      clk_en = 1;
      gpio_enable_in = g;
      software_reset_command = 0;
      enable_source[0] = SRC_ALWAYS;
      enable_source[1] = SRC_GPIO;
      enable_source[2] = SRC_GPIO;
      enable_source[3] = SRC_SERIAL;
      serial_channel_enable = 4'hF;
      channel_reenable = 0;
      ovp_follow = '0;
      ovp_follow[1][2] = 1;
      ocp_follow = '0;
      ovp_trip = 0;
      ocp_trip = 0;
      input_sense = {v, v};
      for (int i = 0; i < NUM_VIN; i++) uv_cfg[i] = '{warn: 8'h40, fault: 8'h30};
      uv_auto_restart = 1;
      temp_sense = 7'h40;
      thermal_fault_threshold = 7'h50;
      thermal_restart_threshold = 7'h48;
      ot_margin_large = 0;
      ot_auto_restart = 1;
      programmable_dead_time = 0;
      rise_dead_time = $urandom;
      fall_dead_time = $urandom;
      pwm_period_cycles = 16'($urandom_range(0, 16'h03FF));
      pwm_demand = 0;
      step(5);
      reset = 0;
      want_en = 1;
      step(3);
      chk("ack early", serial_ack_allowed, 0);
      supply_good = 1;
      step(2);
      chk("ready sync", device_ready, 0);
      step(1);
      chk("ready", device_ready, 1);
      chk("ack", serial_ack_allowed, 1);
      chk("start", channel_active, exp_on(g, 0));
      step(2);
      chk("serial on", channel_active, exp_on(g, 1));
      chk("primary_supply_input", input_one_voltage, v);
      chk("secondary_supply_input", input_two_voltage, v);
      input_sense[1] = 8'h30;
      step(1);
      chk("uv shut", channel_active, 0);
      chk("uv fault", protection_flag_status.uv_fault, 2'b10);
      chk("uv warn", protection_flag_status.uv_warn, 2'b10);
      chk("uv gpio", uv_warning_gpio, 1);
      input_sense[1] = 8'h40;
      step(3);
      chk("uv hold", channel_active, 0);
      input_sense[1] = 8'h41;
      wait_act(exp_on(g, 1));
      temp_sense = 7'h4E;
      step(3);
      chk("ot warn 5", protection_flag_status.ot_warn, 0);
      ot_margin_large = 1;
      step(3);
      chk("ot warn 10", protection_flag_status.ot_warn, 1);
      chk("ot no fault", protection_flag_status.ot_fault, 0);
      temp_sense = 7'h7F;
      step(3);
      chk("ot shut", channel_active, 0);
      chk("ot flags", {protection_flag_status.ot_warn, protection_flag_status.ot_fault}, 3);
      chk("ot ready", device_ready, 1);
      chk("temp high", junction_temperature, 7'h68);
      temp_sense = 7'h49;
      step(3);
      chk("ot latched", channel_active, 0);
      chk("temp", junction_temperature, 7'h49);
      temp_sense = 7'h10;
      wait_act(exp_on(g, 1));
      chk("temp low", junction_temperature, 7'h28);
      gpio_enable_in = 4'hF;
      wait_act(4'hF);
      ovp_trip = 4'b0010;
      step(1);
      ovp_trip = 0;
      chk("ovp shut", channel_active, 4'b1001);
      chk("ovp flag", protection_flag_status.output_overvoltage_protection[1], 1);
      step(5);
      chk("ovp held", channel_active, 4'b1001);
      channel_reenable = 4'b0110;
      step(1);
      channel_reenable = 0;
      wait_act(4'hF);
      ocp_trip = 4'b0001;
      step(1);
      ocp_trip = 0;
      chk("ocp shut", channel_active, 4'b1110);
      chk("ocp flag", protection_flag_status.overcurrent_protection[0], 1);
      step(RST - 1);
      chk("ocp wait", channel_active[0], 0);
      step(3);
      chk("ocp back", channel_active, 4'hF);
      // Built-in gap first, then programmable rise gap at two cycles per count
      rnd = 0;
      pwm_period_cycles = 16'h0200;
      for (int m = 0; m < 2; m++) begin
         programmable_dead_time = m[0];
         gap_edges(n);
         chk("dead time", n, exp_gap(m[0], rise_dead_time[0], pwm_period_cycles));
      end
      rnd = 1;
      software_reset_command = 1;
      step(1);
      software_reset_command = 0;
      chk("sr ready", device_ready, 0);
      chk("sr off", channel_active, 0);
      step(2);
      chk("sr back", device_ready, 1);
      want_en = 0;
      step(2);
      chk("off sync", device_ready, 1);
      step(1);
      chk("off", device_ready, 0);
      chk("off chans", channel_active, 0);
      want_en = 1;
      step(3);
      chk("on again", device_ready, 1);
      summarize();
   end
endmodule
